// ===== nfh_fifo.sv
// Synchronous FIFO for data bytes between user and flash port.
// Assumes one clock; valid/ready on both sides.
`timescale 1ns/1ps
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== nfh_flash_model.sv
// Behavioural flash device facing the host port controller.
// Assumes io is resolved outside and busy pulls an open-drain line low.
`timescale 1ns/1ps
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int BUSY_NS = 1000,
  parameter int RST_NS  = 400,
  parameter int ACC_NS  = 8
) (
  input  wire nfh_pkg::nfh_strobe_s pins,
  input  wire logic [7:0]           io,
  output logic      [7:0]           dq,
  output logic                      dq_oe,
  output logic                      rb_low,
  output int                        n_viol
);
  import nfh_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] pg [PAGE_BYTES];
  logic [7:0] a [4];
  logic [1:0] mode;
  logic       fail;
  logic       first;
  int         acnt, col, row, bns;
  realtime    t_addr;
  event       kick;

  initial begin
    dq = 8'h00;
    dq_oe = 1'b0;
    rb_low = 1'b0;
    n_viol = 0;
    mode = 2'h0;
    fail = 1'b0;
    first = 1'b0;
    acnt = 0;
  end

  function automatic logic [7:0] rd(int key);
    return mem.exists(key) ? mem[key] : 8'hff;
  endfunction

  task automatic go_busy(int ns);
    bns = ns;
    -> kick;
  endtask

  always @(kick) begin
    rb_low = 1'b1;
    #(bns);
    rb_low = 1'b0;
  end

  task automatic do_cmd(logic [7:0] c);
    int base;
    base = row - row % PAGES_PER_BLK;
    if (rb_low && c != CMD_RESET && c != CMD_STATUS) n_viol++;
    case (c)
      CMD_READ_SETUP: begin
        mode = 2'h0;
        acnt = 0;
      end
      CMD_PROG_SETUP: begin
        mode = 2'h1;
        acnt = 0;
        first = 1'b1;
        fail = 1'b0;
        pg = '{default: 8'hff};
      end
      CMD_ERASE_SETUP: begin
        mode = 2'h2;
        acnt = 0;
        fail = 1'b0;
      end
      CMD_STATUS: mode = 2'h3;
      CMD_READ_EXEC: begin
        if (acnt != 4) n_viol++;
        for (int i = 0; i < PAGE_BYTES; i++)
          pg[i] = rd(row * PAGE_BYTES + i);
        go_busy(BUSY_NS);
      end
      CMD_PROG_EXEC, CMD_CACHE_EXEC: begin
        if (acnt != 4) n_viol++;
        if (pins.wp_n) begin
          for (int i = 0; i < PAGE_BYTES; i++)
            mem[row * PAGE_BYTES + i] = rd(row * PAGE_BYTES + i) & pg[i];
        end else
          fail = 1'b1;
        go_busy(BUSY_NS);
      end
      CMD_ERASE_EXEC: begin
        if (acnt != 2) n_viol++;
        if (pins.wp_n) begin
          for (int k = base * PAGE_BYTES;
               k < (base + PAGES_PER_BLK) * PAGE_BYTES; k++)
            if (mem.exists(k)) mem.delete(k);
        end else
          fail = 1'b1;
        go_busy(BUSY_NS);
      end
      CMD_RESET: begin
        mode = 2'h0;
        acnt = 0;
        go_busy(RST_NS);
      end
      default: n_viol++;
    endcase
  endtask

  task automatic do_addr(logic [7:0] b);
    if (acnt < ((mode == 2'h2) ? 2 : 4)) begin
      a[(mode == 2'h2) ? acnt + 2 : acnt] = b;
      if (mode != 2'h2 && acnt == 1 && b[7:4] != 4'h0) n_viol++;
      acnt++;
      col = {a[1][3:0], a[0]};
      row = {a[3], a[2]};
      t_addr = $realtime;
    end
  endtask

  task automatic do_data(logic [7:0] b);
    if (first && $realtime - t_addr < 100.0) n_viol++;
    first = 1'b0;
    if (col < PAGE_BYTES) pg[col] = b;
    col++;
  endtask

  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      if (pins.cle) do_cmd(io);
      else if (pins.ale) do_addr(io);
      else do_data(io);
    end
  end

  always @(negedge pins.re_n) begin
    if (!pins.ce_n) begin
      #(ACC_NS);
      dq = (mode == 2'h3) ? {pins.wp_n, ~rb_low, 5'h00, fail}
                          : pg[col % PAGE_BYTES];
      dq_oe = 1'b1;
      if (mode != 2'h3) col++;
    end
  end

  always @(posedge pins.re_n or posedge pins.ce_n) dq_oe = 1'b0;
endmodule

// ===== nfh_host.sv
// NAND flash host controller: sequences command, address, data cycles.
// Assumes flash pins attached directly; io_bus and ready_busy_n are
// resolved outside from the enable and open-drain pull-up.
`timescale 1ns/1ps
module nfh_host
  import nfh_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire nfh_pkg::nfh_req_s req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              write_protect,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  output logic      [7:0]        rd_data,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic                   done,
  output logic      [7:0]        status,
  output nfh_pkg::nfh_strobe_s   pins,
  output logic      [7:0]        io_out,
  output logic                   io_oe,
  input  wire logic [7:0]        io_in,
  input  wire logic              ready_busy_n
);
  import nfh_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rb_sync;
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic       rb_ready;

  always_ff @(posedge clock) begin
    if (rst) begin
      rb_sync <= 2'h0;
      io_s1   <= 8'h00;
      io_s2   <= 8'h00;
    end else begin
      rb_sync <= {rb_sync[0], ready_busy_n};
      io_s1   <= io_in;
      io_s2   <= io_s1;
    end
  end
  assign rb_ready = rb_sync[1];

  // ----------------------------------------------------------------------
  // Write data FIFO
  // ----------------------------------------------------------------------
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;

  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD1  = 4'b0001,
    ST_ADDR  = 4'b0011,
    ST_GAP   = 4'b0010,
    ST_WDATA = 4'b0110,
    ST_CMD2  = 4'b0111,
    ST_BUSY  = 4'b0101,
    ST_RDATA = 4'b0100,
    ST_STAT  = 4'b1100
  } nfh_state_e;

  nfh_state_e  state;
  nfh_req_s    cur;
  logic [2:0]  addr_idx;
  logic [11:0] remain;
  logic [15:0] wait_cnt;
  logic [1:0]  phase;
  logic        strobe_lo;
  logic [7:0]  wbyte;
  logic [2:0]  addr_last;
  logic        rd_pending;

  // Byte for address cycle n, low bits first
  function automatic logic [7:0] addr_byte(input nfh_req_s r,
                                           input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      3'h0: b = r.col[7:0];
      3'h1: b = {4'h0, r.col[11:8]};
      3'h2: b = r.row[7:0];
      default: b = r.row[15:8];
    endcase
    return b;
  endfunction

  assign addr_last = (cur.op == NFH_OP_ERASE) ? 3'h1 : 3'h3;
  assign req_ready = (state == ST_IDLE);
  // One strobe cycle: phase 0..1 low, 2..3 high
  assign strobe_lo = (phase < 2'(STROBE_LOW_CYC));

  // Byte driven on the bus in write states
  always_comb begin
    wbyte = 8'h00;
    unique case (state)
      ST_CMD1: begin
        unique case (cur.op)
          NFH_OP_READ:   wbyte = CMD_READ_SETUP;
          NFH_OP_ERASE:  wbyte = CMD_ERASE_SETUP;
          NFH_OP_STATUS: wbyte = CMD_STATUS;
          NFH_OP_RESET:  wbyte = CMD_RESET;
          default:       wbyte = CMD_PROG_SETUP;
        endcase
      end
      ST_ADDR:  wbyte = (cur.op == NFH_OP_ERASE) ?
                        addr_byte(cur, addr_idx + 3'h2) :
                        addr_byte(cur, addr_idx);
      ST_WDATA: wbyte = fifo_data;
      ST_CMD2: begin
        unique case (cur.op)
          NFH_OP_READ:  wbyte = CMD_READ_EXEC;
          NFH_OP_CACHE: wbyte = CMD_CACHE_EXEC;
          NFH_OP_ERASE: wbyte = CMD_ERASE_EXEC;
          default:      wbyte = CMD_PROG_EXEC;
        endcase
      end
      default: wbyte = 8'h00;
    endcase
  end

  assign fifo_pop = (state == ST_WDATA) && (phase == 2'h3) && fifo_valid;

  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= ST_IDLE;
      cur      <= '0;
      addr_idx <= 3'h0;
      remain   <= 12'h000;
      wait_cnt <= 16'h0000;
      phase    <= 2'h0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          phase <= 2'h0;
          // busy wait before accepting a new request other than reset or status
          if (req_valid && (rb_ready || req.op == NFH_OP_RESET ||
                            req.op == NFH_OP_STATUS)) begin
            cur   <= req;
            state <= ST_CMD1;
          end
        end
        ST_CMD1: begin
          phase <= phase + 2'h1;
          if (phase == 2'h3) begin
            addr_idx <= 3'h0;
            remain   <= cur.count;
            if (cur.op == NFH_OP_STATUS) begin
              wait_cnt <= 16'(READ_ACCESS_DELAY_CYC + 2);
              state    <= ST_STAT;
            end else if (cur.op == NFH_OP_RESET) begin
              wait_cnt <= 16'(RESET_BUSY_CYC);
              state    <= ST_BUSY;
            end else begin
              state <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          phase <= phase + 2'h1;
          if (phase == 2'h3) begin
            addr_idx <= addr_idx + 3'h1;
            if (addr_idx == addr_last) begin
              if (cur.op == NFH_OP_PROG || cur.op == NFH_OP_CACHE) begin
                wait_cnt <= 16'(ADDR_DATA_GAP_CYC);
                state    <= ST_GAP;
              end else begin
                state <= ST_CMD2;
              end
            end
          end
        end
        ST_GAP: begin
          phase <= 2'h0;
          if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end else begin
            state <= (remain == 12'h000) ? ST_CMD2 : ST_WDATA;
          end
        end
        ST_WDATA: begin
          // Stall on an empty FIFO with strobe high
          if (phase != 2'h0 || fifo_valid) begin
            phase <= phase + 2'h1;
          end
          if (fifo_pop) begin
            remain <= remain - 12'h001;
            if (remain == 12'h001) begin
              state <= ST_CMD2;
            end
          end
        end
        ST_CMD2: begin
          phase <= phase + 2'h1;
          if (phase == 2'h3) begin
            wait_cnt <= 16'(RESET_BUSY_CYC);
            state    <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // ignore ready for the first 9 cycles while busy shows, then wait for ready
          phase <= 2'h0;
          if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
          if (rb_ready && (wait_cnt < 16'(RESET_BUSY_CYC - 8) ||
                           wait_cnt == 16'h0000)) begin
            if (cur.op == NFH_OP_READ && cur.count != 12'h000) begin
              state <= ST_RDATA;
            end else begin
              done  <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          // read strobe pulses while output side accepts
          if (phase != 2'h0 || !rd_pending) begin
            phase <= phase + 2'h1;
          end
          if (phase == 2'h3) begin
            remain <= remain - 12'h001;
            if (remain == 12'h001) begin
              state <= ST_IDLE;
              done  <= 1'b1;
            end
          end
        end
        ST_STAT: begin
          if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end else begin
            done  <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read capture and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data    <= 8'h00;
      rd_pending <= 1'b0;
      status     <= 8'h00;
    end else begin
      if (rd_valid && rd_ready) begin
        rd_pending <= 1'b0;
      end
      // Sample once the byte has passed both sync stages
      if (state == ST_RDATA && phase == 2'h3) begin
        rd_data    <= io_s2;
        rd_pending <= 1'b1;
      end
      if (state == ST_STAT && wait_cnt == 16'h0001) begin
        status <= io_s2;
      end
    end
  end
  assign rd_valid = rd_pending;

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic wr_cyc;
  assign wr_cyc = (state == ST_CMD1) || (state == ST_ADDR) ||
                  (state == ST_CMD2) ||
                  (state == ST_WDATA && (phase != 2'h0 || fifo_valid));

  always_ff @(posedge clock) begin
    if (rst) begin
      pins   <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                  re_n: 1'b1, wp_n: 1'b0};
      io_out <= 8'h00;
      io_oe  <= 1'b0;
    end else begin
      pins.ce_n <= (state == ST_IDLE) && !req_valid;
      pins.cle  <= (state == ST_CMD1) || (state == ST_CMD2);
      pins.ale  <= (state == ST_ADDR);
      pins.we_n <= !(wr_cyc && strobe_lo);
      pins.re_n <= !((state == ST_RDATA && strobe_lo) ||
                     state == ST_STAT);
      pins.wp_n <= !write_protect;
      io_out    <= wbyte;
      io_oe     <= wr_cyc;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_strobe_one_latch: assert property (@(posedge clock) disable iff (rst)
    !(pins.cle && pins.ale)) else $error("cle and ale both high");
  chk_read_bus_free: assert property (@(posedge clock) disable iff (rst)
    !pins.re_n |-> !io_oe) else $error("bus driven during read");
  chk_we_select: assert property (@(posedge clock) disable iff (rst)
    !pins.we_n |-> !pins.ce_n) else $error("write while deselected");
  chk_addr_nibble: assert property (@(posedge clock) disable iff (rst)
    (state == ST_ADDR && addr_idx == 3'h1 && cur.op != NFH_OP_ERASE)
      |-> wbyte[7:4] == 4'h0) else $error("column high nibble set");
  chk_erase_rows: assert property (@(posedge clock) disable iff (rst)
    (state == ST_ADDR && cur.op == NFH_OP_ERASE) |-> addr_idx <= 3'h1)
    else $error("erase sent column cycles");
  chk_gap_len: assert property (@(posedge clock) disable iff (rst)
    $rose(state == ST_GAP) |-> (state == ST_GAP)[*5])
    else $error("address to data gap short");
  chk_busy_select: assert property (@(posedge clock) disable iff (rst)
    (state == ST_BUSY) |=> !pins.ce_n) else $error("select dropped");
  chk_setup_addr: assert property (@(posedge clock) disable iff (rst)
    (state == ST_CMD1 && phase == 2'h3 && (cur.op == NFH_OP_READ ||
     cur.op == NFH_OP_PROG)) |=> state == ST_ADDR)
    else $error("setup not followed by address");
  chk_wait_ready: assert property (@(posedge clock) disable iff (rst)
    (state == ST_IDLE && req_valid && !rb_ready &&
     req.op == NFH_OP_READ) |=> state == ST_IDLE)
    else $error("command while busy");
endmodule

// ===== nfh_pkg.sv
// Package for the NAND flash host port controller.
// Assumes a 50 MHz single clock domain on the controller side.
package nfh_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 20;
  localparam int ADDR_DATA_GAP_NS = 100;
  localparam int ADDR_DATA_GAP_CYC =
    (ADDR_DATA_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_BUSY_US    = 5;
  localparam int RESET_BUSY_CYC   = RESET_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC   = 2;
  localparam int STROBE_HIGH_CYC  = 2;
  localparam int READ_ACCESS_DELAY_CYC = 2;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_BITS    = 28;
  localparam int COL_BITS     = 12;
  localparam int ROW_BITS     = 16;
  localparam int PAGE_BYTES   = 2112;
  localparam int SPARE_COL    = 2048;
  localparam int PAGES_PER_BLK = 64;
  localparam int BLOCKS       = 1024;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_EXEC   = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PROG_EXEC   = 8'h10;
  localparam logic [7:0] CMD_CACHE_EXEC  = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_EXEC  = 8'hd0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_RESET       = 8'hff;

  typedef enum logic [2:0] {
    NFH_OP_READ   = 3'h0,
    NFH_OP_PROG   = 3'h1,
    NFH_OP_CACHE  = 3'h2,
    NFH_OP_ERASE  = 3'h3,
    NFH_OP_STATUS = 3'h4,
    NFH_OP_RESET  = 3'h5
  } nfh_op_e;

  typedef struct packed {
    nfh_op_e              op;
    logic [COL_BITS-1:0]  col;
    logic [ROW_BITS-1:0]  row;
    logic [11:0]          count;
  } nfh_req_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
  } nfh_strobe_s;

endpackage

// ===== tb.sv
// Self-checking bench for the flash host port controller.
// Assumes the behavioural flash model and a pulled-up busy line.
`timescale 1ns/1ps
module tb;
  import nfh_pkg::*;
  logic        clock, rst, req_valid, req_ready, write_protect;
  logic        wr_valid, wr_ready, rd_valid, rd_ready, done;
  logic        io_oe, dq_oe, rb_low;
  logic [7:0]  wr_data, rd_data, status, io_out, dq, last;
  nfh_req_s    req;
  nfh_strobe_s pins;
  wire  [7:0]  io_bus;
  wire         ready_busy_n;
  int          n_viol, n_fail, samples_checked;
  logic [7:0]  rq [$];

  // Released bus shows the inverse of its last driven value
  assign io_bus = io_oe ? io_out : (dq_oe ? dq : ~last);
  assign ready_busy_n = ~rb_low;
  always @(io_oe or dq_oe or io_out or dq) begin
    if (io_oe) last = io_out;
    else if (dq_oe) last = dq;
  end

  nfh_host nfh_host_inst (
    .clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .write_protect(write_protect),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .done(done), .status(status), .pins(pins), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(ready_busy_n)
  );
  nfh_flash_model nfh_flash_model_inst (
    .pins(pins), .io(io_bus), .dq(dq), .dq_oe(dq_oe),
    .rb_low(rb_low), .n_viol(n_viol)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Reader stalls every other cycle
  always @(posedge clock) begin
    rd_ready <= ~rd_ready;
    if (rd_valid && rd_ready) rq.push_back(rd_data);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp8(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic run_op(nfh_op_e o, int c, int r, int n);
    int k;
    @(posedge clock);
    req <= '{op: o, col: c[11:0], row: r[15:0], count: n[11:0]};
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (req_ready !== 1'b0 && k < 100);
    req_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge clock);
      k++;
    end
    cmp8("done", 8'h01, {7'h00, done});
  endtask

  task automatic push(int n, logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      wr_data <= b0 + 8'(i);
      wr_valid <= 1'b1;
      do @(posedge clock); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
  endtask

  task automatic chk_rd(int n, logic [7:0] b0, logic step);
    int k;
    k = 0;
    while (rq.size() < n && k < 50) begin
      @(posedge clock);
      k++;
    end
    cmp8("rd_count", 8'(n), 8'(rq.size()));
    for (int i = 0; i < n && rq.size() > 0; i++)
      cmp8("rd_data", b0 + (step ? 8'(i) : 8'h00), rq.pop_front());
    rq.delete();
  endtask

  task automatic t_prog_spare();
    push(8, 8'ha0);
    @(posedge clock);
    cmp8("wr_ready", 8'h00, {7'h00, wr_ready});
    run_op(NFH_OP_PROG, 2044, 5, 8);
    run_op(NFH_OP_READ, 2044, 5, 8);
    chk_rd(8, 8'ha0, 1'b1);
  endtask

  task automatic t_cache();
    push(3, 8'h31);
    run_op(NFH_OP_CACHE, 0, 70, 3);
    run_op(NFH_OP_READ, 0, 70, 3);
    chk_rd(3, 8'h31, 1'b1);
  endtask

  task automatic t_erase();
    push(1, 8'h12);
    run_op(NFH_OP_PROG, 0, 6, 1);
    run_op(NFH_OP_ERASE, 0, 5, 0);
    run_op(NFH_OP_READ, 2046, 5, 2);
    chk_rd(2, 8'hff, 1'b0);
    run_op(NFH_OP_READ, 0, 6, 1);
    chk_rd(1, 8'hff, 1'b0);
  endtask

  task automatic t_protect();
    write_protect <= 1'b1;
    push(2, 8'h55);
    run_op(NFH_OP_PROG, 0, 9, 2);
    run_op(NFH_OP_STATUS, 0, 0, 0);
    cmp8("status", 8'h41, status);
    write_protect <= 1'b0;
    run_op(NFH_OP_READ, 0, 9, 2);
    chk_rd(2, 8'hff, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    write_protect = 1'b0;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    rd_ready = 1'b0;
    last = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    run_op(NFH_OP_STATUS, 0, 0, 0);
    cmp8("status", 8'hc0, status);
    t_prog_spare();
    t_cache();
    t_erase();
    t_protect();
    run_op(NFH_OP_RESET, 0, 0, 0);
    // Second reset; first read must wait for synced ready
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    run_op(NFH_OP_READ, 0, 70, 3);
    chk_rd(3, 8'h31, 1'b1);
    cmp8("viol", 8'h00, n_viol[7:0]);
    test_done();
  end

  // Span well beyond the expected thousand or so cycles
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule
